// file: common/asarc_pkg.sv
package asarc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RESULT = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0c;
    localparam logic [7:0] OFF_STATE = 8'h10;
    // Control register fields
    localparam int CTRL_PWR = 0;
    localparam int CTRL_CSEL = 1;
    localparam int CTRL_JUST = 3;
    localparam int CTRL_GO = 4;
    // Event bits, shared by status and mask
    localparam int EV_DONE = 0;
    localparam int EV_ABORT = 1;
    localparam int EV_W = 2;
    // Conversion clock select codes
    localparam logic [1:0] CSEL_DIV8 = 2'h0;
    localparam logic [1:0] CSEL_DIV32 = 2'h1;
    localparam logic [1:0] CSEL_DIV64 = 2'h2;
    localparam logic [1:0] CSEL_RC = 2'h3;
    // Divider terminal counts for the clocked settings
    localparam logic [5:0] DIV8_TOP = 6'h07;
    localparam logic [5:0] DIV32_TOP = 6'h1f;
    localparam logic [5:0] DIV64_TOP = 6'h3f;
    // One instruction cycle in system clocks
    localparam int INSTR_CLKS = 4;
    // Conversion length in conversion clock ticks
    localparam int CONV_TICKS_DEF = 12;
    // Result widths
    localparam int RESULT_W = 10;
    localparam int PAIR_W = 16;
    localparam logic [1:0] STATE_RST = 2'h0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Converter sequencing states
    typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_DELAY, ST_CONV} asarc_state_t;

    // Places the raw result in the register pair, zero filled
    function automatic logic [PAIR_W-1:0] justify(
        input logic [RESULT_W-1:0] raw,
        input logic left
    );
        justify = left ? {raw, {(PAIR_W-RESULT_W){1'b0}}}
                       : {{(PAIR_W-RESULT_W){1'b0}}, raw};
    endfunction : justify
endpackage : asarc_pkg

// file: common/asarc_conv_if.sv
`timescale 1ns/1ps
interface asarc_conv_if;
    import asarc_pkg::*;
    logic start; // One-cycle start request
    logic abort; // One-cycle abort
    logic [1:0] clkSel; // Conversion clock select
    logic busy; // Conversion running
    logic done; // One-cycle completion pulse
    logic [RESULT_W-1:0] data; // Converted value, valid with done
    modport ctrl(output start, abort, clkSel, input busy, done, data);
    modport engine(input start, abort, clkSel, output busy, done, data);
endinterface : asarc_conv_if

// file: hw/asarc_conv_timer.sv
`timescale 1ns/1ps
module asarc_conv_timer import asarc_pkg::*; #(
    parameter int CONV_TICKS = CONV_TICKS_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins from the analog side
    input wire logic rcOscIn,
    input wire logic [RESULT_W-1:0] sampleIn,
    // Sequencer side
    asarc_conv_if.engine conv
);
    // Counter below is eight bits wide
    if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_check
        $error("CONV_TICKS out of range");
    end

    logic rcSync1; // First stage, read only by rcSync2
    logic rcSync2;
    logic rcPrev; // For edge detection
    logic [RESULT_W-1:0] sampSync1;
    logic [RESULT_W-1:0] sampSync2;
    logic [5:0] divCnt;
    logic [7:0] tickCnt;
    logic busyQ;
    logic doneQ;
    logic [RESULT_W-1:0] dataQ;

    // Divider top for the selected clock
    wire rcSel = conv.clkSel == CSEL_RC;
    wire [5:0] divTop = (conv.clkSel == CSEL_DIV8) ? DIV8_TOP :
                        (conv.clkSel == CSEL_DIV32) ? DIV32_TOP : DIV64_TOP;
    wire tick = rcSel ? (rcSync2 && !rcPrev) : (divCnt == divTop);
    wire lastTick = tickCnt == 8'(CONV_TICKS - 1);

    assign conv.busy = busyQ;
    assign conv.done = doneQ;
    assign conv.data = dataQ;

    // Pin synchronisers; the sample is assumed steady during conversion
    always_ff @(posedge clk) begin
        rcSync1 <= rcOscIn;
        rcSync2 <= rcSync1;
        rcPrev <= rcSync2;
        sampSync1 <= sampleIn;
        sampSync2 <= sampSync1;
    end

    // Divider only runs while converting, to save power
    always_ff @(posedge clk) begin
        if (!reset_n || !busyQ || divCnt == divTop) begin
            divCnt <= 6'h00;
        end else begin
            divCnt <= divCnt + 6'h01;
        end
    end

    // Tick counting; abort wins over everything
    always_ff @(posedge clk) begin
        doneQ <= 1'b0;
        if (!reset_n || conv.abort) begin
            busyQ <= 1'b0;
            tickCnt <= 8'h00;
        end else if (conv.start) begin
            busyQ <= 1'b1;
            tickCnt <= 8'h00;
        end else if (busyQ && tick) begin
            // Final tick ends the conversion
            if (lastTick) begin
                busyQ <= 1'b0;
                doneQ <= 1'b1;
            end
            tickCnt <= tickCnt + 8'h01;
        end
        if (!reset_n) begin
            doneQ <= 1'b0;
        end
    end

    // Captured value, deliberately without reset
    always_ff @(posedge clk) begin
        if (busyQ && tick && lastTick && !conv.abort) begin
            dataQ <= sampSync2;
        end
    end
endmodule : asarc_conv_timer

// file: hw/asarc_control.sv
`timescale 1ns/1ps
module asarc_control import asarc_pkg::*; #(
    parameter int CONV_TICKS = CONV_TICKS_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Core halt level, same clock
    input wire logic coreHalt,
    // Analog side pins
    input wire logic rcOscIn,
    input wire logic [RESULT_W-1:0] sampleIn,
    // Status to the system
    output logic converterEnable,
    output logic wakeEvent,
    output logic irq,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Known offsets of the map
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = a == OFF_CTRL || a == OFF_RESULT || a == OFF_STATUS
                || a == OFF_MASK || a == OFF_STATE;
    endfunction : isMapped

    asarc_conv_if conv();

    asarc_conv_timer #(
        .CONV_TICKS(CONV_TICKS)
    ) u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .rcOscIn(rcOscIn),
        .sampleIn(sampleIn),
        .conv(conv)
    );

    // Software controls
    logic powerOn; // Stays set through automatic power-down
    logic [1:0] clkSel;
    logic justifySel;
    logic go; // Request, cleared by hardware at completion
    logic [EV_W-1:0] evStatus;
    logic [EV_W-1:0] evMask;
    logic [PAIR_W-1:0] result; // No reset on purpose
    // Sequencer
    asarc_state_t state;
    asarc_state_t next_state;
    logic [1:0] delayCnt;
    // Bus holding registers
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;

    // Write channel decode
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    wire doWrite = awHeld && wHeld && !s_axi_bvalid;
    wire wrLow = doWrite && wStrb[0];
    wire wrCtrl = wrLow && awAddr == OFF_CTRL;
    wire wrStatus = wrLow && awAddr == OFF_STATUS;
    wire wrMask = wrLow && awAddr == OFF_MASK;
    // Read channel decode
    assign s_axi_arready = !s_axi_rvalid;
    wire arFire = s_axi_arvalid && s_axi_arready;
    wire [31:0] ctrlRd = {27'h0, go, justifySel, clkSel, powerOn};
    wire [31:0] stateRd = {29'h0, coreHalt, state};
    wire [31:0] readMux =
        (s_axi_araddr == OFF_CTRL) ? ctrlRd :
        (s_axi_araddr == OFF_RESULT) ? {16'h0, result} :
        (s_axi_araddr == OFF_STATUS) ? {30'h0, evStatus} :
        (s_axi_araddr == OFF_MASK) ? {30'h0, evMask} :
        (s_axi_araddr == OFF_STATE) ? stateRd : 32'h0;

    // Sequencer conditions
    wire rcSel = clkSel == CSEL_RC;
    wire killNow = !powerOn || (coreHalt && !rcSel);
    wire inConv = state == ST_CONV;
    wire inDelay = state == ST_DELAY;
    wire doneHere = conv.done && inConv && !killNow;
    wire delayEnd = inDelay && delayCnt == 2'(INSTR_CLKS - 1);
    wire abortNow = (inConv || inDelay) && killNow;
    wire [EV_W-1:0] evSet = {abortNow, doneHere};

    // Engine control
    assign conv.clkSel = clkSel;
    assign conv.abort = abortNow;
    // Clocked settings start at once, RC after the delay
    assign conv.start = !killNow && ((state == ST_IDLE && go && !rcSel)
        || delayEnd);
    assign converterEnable = state != ST_OFF;
    assign irq = |(evStatus & evMask);

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                // Wakes only once the halt is over
                if (powerOn && !coreHalt) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (killNow) begin
                    next_state = ST_OFF;
                end else if (go) begin
                    next_state = rcSel ? ST_DELAY : ST_CONV;
                end
            end
            ST_DELAY: begin
                if (killNow) begin
                    next_state = ST_OFF;
                end else if (delayEnd) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (killNow) begin
                    next_state = ST_OFF;
                end else if (doneHere) begin
                    // Masked completion in halt shuts down
                    next_state = (coreHalt && !evMask[EV_DONE]) ? ST_OFF
                                                                 : ST_IDLE;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // Sequencer and delay counter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= ST_OFF;
            delayCnt <= 2'h0;
        end else begin
            state <= next_state;
            delayCnt <= inDelay ? delayCnt + 2'h1 : 2'h0;
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            powerOn <= 1'b0;
            clkSel <= CSEL_DIV8;
            justifySel <= 1'b0;
        end else if (wrCtrl) begin
            powerOn <= wData[CTRL_PWR];
            clkSel <= wData[CTRL_CSEL +: 2];
            justifySel <= wData[CTRL_JUST];
        end
    end

    // Request flag; set only while powered
    always_ff @(posedge clk) begin
        if (!reset_n || doneHere || abortNow || next_state == ST_OFF) begin
            go <= 1'b0;
        end else if (wrCtrl && wData[CTRL_GO] && converterEnable) begin
            go <= 1'b1;
        end
    end

    // Result pair load
    always_ff @(posedge clk) begin
        if (doneHere) begin
            result <= justify(conv.data, justifySel);
        end
    end

    // Sticky events, set beats write-one-clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            evStatus <= 2'h0;
            evMask <= 2'h0;
            wakeEvent <= 1'b0;
        end else begin
            evStatus <= (evStatus & ~(wrStatus ? wData[EV_W-1:0] : 2'h0)) | evSet;
            if (wrMask) begin
                evMask <= wData[EV_W-1:0];
            end
            wakeEvent <= doneHere && coreHalt && evMask[EV_DONE];
        end
    end

    // Write address and data hold
    always_ff @(posedge clk) begin
        if (!reset_n || doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
            end
        end
        if (s_axi_awvalid && s_axi_awready) begin
            awAddr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (arFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readMux;
            s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Conversion keeps running in halt only with RC
    a_halt_conv_rc: assert property (
        conv.busy && coreHalt && $past(coreHalt) |-> rcSel)
        else $error("conversion ran in halt without RC clock");

    // RC start only in the fourth consecutive delay cycle
    a_rc_start_delay: assert property (
        conv.start && rcSel |-> inDelay && $past(inDelay, 3))
        else $error("RC start not delayed one instruction cycle");

    // Completion clears request and loads justified value
    a_done_load: assert property (
        doneHere |=> !go && result == justify($past(conv.data), justifySel))
        else $error("completion did not clear request or load result");

    // Enabled completion in halt wakes the core
    a_wake_on_done: assert property (
        doneHere && coreHalt && evMask[EV_DONE] |=> wakeEvent && state == ST_IDLE)
        else $error("no wake after completion in halt");

    // Masked completion in halt powers down
    a_masked_off: assert property (
        doneHere && coreHalt && !evMask[EV_DONE]
        |=> state == ST_OFF && powerOn && !wakeEvent)
        else $error("masked completion did not power down");

    // Non-RC halt aborts and powers down, power bit kept
    a_halt_abort: assert property (
        coreHalt && !rcSel && powerOn && (inConv || inDelay)
        |-> conv.abort ##1 (state == ST_OFF && powerOn && evStatus[EV_ABORT]))
        else $error("non-RC halt did not abort");

    // Nothing converts while off
    a_off_quiet: assert property (
        state == ST_OFF |-> !conv.start && !converterEnable ##1 !conv.busy)
        else $error("activity while powered down");

    // Reset returns the controls and powers down
    a_reset_state: assert property (disable iff (1'b0)
        !reset_n |=> state == ST_OFF && !powerOn && !go && !conv.busy)
        else $error("reset did not power down");

    // Unused pair bits are zero
    a_justify_zero: assert property (
        $past(doneHere) |-> (justifySel ? result[5:0] == 6'h0
                                        : result[15:10] == 6'h0))
        else $error("result pair fill bits not zero");

    // Requests ignored while off
    a_off_no_go: assert property (
        state == ST_OFF && !go |=> !go)
        else $error("request accepted while powered off");

    c_wake_in_halt: cover property (doneHere && coreHalt && evMask[EV_DONE]);
    c_masked_off: cover property (doneHere && coreHalt && !evMask[EV_DONE]);
    c_halt_abort: cover property (abortNow && coreHalt);
    c_plain_done: cover property (doneHere && !coreHalt && !rcSel);
endmodule : asarc_control

// file: tb/asarc_core_model.sv
`timescale 1ns/1ps
module asarc_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Requests from the software sequence
    input wire logic haltReq,
    input wire logic rcRun,
    // Core and oscillator pins
    output logic coreHalt,
    output logic rcOscIn
);
    logic [1:0] rcDiv; // Half period count of the RC clock

    // Core enters halt on the edge right after the request write ends
    always_ff @(posedge clk) begin
        coreHalt <= reset_n & haltReq;
    end

    // RC oscillator, held low while not running so no stray tick appears
    always_ff @(posedge clk) begin
        if (!reset_n || !rcRun) begin
            rcDiv <= 2'h0;
            rcOscIn <= 1'b0;
        end else if (rcDiv == 2'h2) begin
            rcDiv <= 2'h0;
            rcOscIn <= ~rcOscIn;
        end else begin
            rcDiv <= rcDiv + 2'h1;
        end
    end
endmodule : asarc_core_model

// file: tb/asarc_control_tb.sv
`timescale 1ns/1ps
module asarc_control_tb import asarc_pkg::*;;
    localparam logic [9:0] SAMPLE = 10'h2a5; // Steady analog value
    logic clk, reset_n, haltReq, rcRun, coreHalt, rcOscIn;
    logic converterEnable, wakeEvent, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdVal;
    logic [1:0] bresp, rresp, lastResp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    int error_cnt = 0;
    int n_checks = 0;
    int wakeCnt = 0; // Wake pulses seen
    int n;
    logic [31:0] ctrlVal; // Control word of the current loop pass

    asarc_control #(.CONV_TICKS(2)) dut (.clk(clk), .reset_n(reset_n), .coreHalt(coreHalt),
        .rcOscIn(rcOscIn), .sampleIn(SAMPLE), .converterEnable(converterEnable),
        .wakeEvent(wakeEvent), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    asarc_core_model core (.clk(clk), .reset_n(reset_n), .haltReq(haltReq), .rcRun(rcRun),
        .coreHalt(coreHalt), .rcOscIn(rcOscIn));

    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Wake pulses last one cycle, so count them at every edge
    always @(posedge clk) begin
        if (wakeEvent === 1'b1) wakeCnt++;
    end
    // Watchdog well past the expected run length
    initial begin
        #(20 * 40000);
        error_cnt++;
        close_out();
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Write: both channels offered together, each released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w, b;
        aw = 0;
        w = 0;
        b = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(posedge clk);
            if (aw && w && bvalid) begin
                b = 1;
                lastResp = bresp;
                bready <= 1'b0;
            end
            if (!aw && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
    endtask : wr

    // Read: data and response taken at the edge where rvalid is seen
    task automatic rd(input logic [7:0] a);
        bit ar, r;
        ar = 0;
        r = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r) begin
            @(posedge clk);
            if (ar && rvalid) begin
                r = 1;
                rdVal = rdata;
                lastResp = rresp;
                rready <= 1'b0;
            end
            if (!ar && arready) begin
                ar = 1;
                arvalid <= 1'b0;
            end
        end
    endtask : rd

    // Polls status until the given event bit sets, bounded
    task automatic wait_status(input int bitIdx);
        n = 0;
        rd(OFF_STATUS);
        while (rdVal[bitIdx] !== 1'b1 && n < 200) begin
            rd(OFF_STATUS);
            n++;
        end
    endtask : wait_status

    task automatic wait_off();
        n = 0;
        while (converterEnable !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_off

    task automatic close_out();
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    initial begin
        reset_n = 0;
        haltReq = 0;
        rcRun = 0;
        awaddr = 0;
        araddr = 0;
        wdata = 0;
        awvalid = 0;
        wvalid = 0;
        bready = 0;
        arvalid = 0;
        rready = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1;
        // Reset state, result untouched, request ignored while off
        rd(OFF_CTRL);
        check("ctrl", rdVal, 32'h0);
        rd(OFF_RESULT);
        check("result", rdVal, {16'h0, 16'hxxxx});
        wr(OFF_CTRL, 32'h10);
        rd(OFF_CTRL);
        check("ctrl", rdVal, 32'h0);
        rd(OFF_STATE);
        check("state", rdVal, 32'h0);
        wr(8'h14, 32'h1);
        check("bresp", {30'h0, lastResp}, {30'h0, RESP_SLVERR});
        rd(8'h14);
        check("rresp", {30'h0, lastResp}, {30'h0, RESP_SLVERR});
        // Clocked settings, both justifications
        wr(OFF_MASK, 32'h1);
        for (int s = 0; s < 3; s++) begin
            ctrlVal = 32'h1 | (s << 1) | (s == 1 ? 32'h8 : 32'h0);
            wr(OFF_CTRL, ctrlVal);
            wr(OFF_CTRL, ctrlVal | 32'h10);
            wait_status(EV_DONE);
            rd(OFF_RESULT);
            if (s == 1) begin
                check("result", rdVal, {16'h0, SAMPLE, 6'h0});
            end else begin
                check("result", rdVal, {22'h0, SAMPLE});
            end
            rd(OFF_CTRL);
            check("ctrl", rdVal, ctrlVal);
            check("irq", {31'h0, irq}, 32'h1);
            wr(OFF_STATUS, 32'h1);
            check("irq", {31'h0, irq}, 32'h0);
        end
        // RC clock through halt with wake enabled, left justified so a fresh load shows
        wr(OFF_CTRL, 32'hf);
        wr(OFF_CTRL, 32'h1f);
        haltReq <= 1;
        // Second delay cycle, core already halted
        rd(OFF_STATE);
        check("state", rdVal, 32'h6);
        rcRun <= 1;
        n = 0;
        while (wakeCnt == 0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        check("wake", wakeCnt, 1);
        check("enable", {31'h0, converterEnable}, 32'h1);
        rd(OFF_RESULT);
        check("result", rdVal, {16'h0, SAMPLE, 6'h0});
        haltReq <= 0;
        rcRun <= 0;
        wr(OFF_STATUS, 32'h1);
        // RC clock through halt with wake disabled
        wr(OFF_MASK, 32'h0);
        wr(OFF_CTRL, 32'h17);
        haltReq <= 1;
        rcRun <= 1;
        wait_off();
        check("wake", wakeCnt, 1);
        rd(OFF_STATUS);
        check("status", rdVal, 32'h1);
        check("irq", {31'h0, irq}, 32'h0);
        rd(OFF_CTRL);
        check("ctrl", rdVal, 32'h7);
        rd(OFF_STATE);
        check("state", rdVal, 32'h4);
        rd(OFF_RESULT);
        check("result", rdVal, {22'h0, SAMPLE});
        haltReq <= 0;
        rcRun <= 0;
        wr(OFF_STATUS, 32'h1);
        // Clocked setting aborted by halt
        wr(OFF_CTRL, 32'h5);
        wr(OFF_CTRL, 32'h15);
        haltReq <= 1;
        wait_off();
        rd(OFF_STATUS);
        check("status", rdVal, 32'h2);
        rd(OFF_CTRL);
        check("ctrl", rdVal, 32'h5);
        wr(OFF_MASK, 32'h2);
        check("irq", {31'h0, irq}, 32'h1);
        wr(OFF_STATUS, 32'h2);
        check("irq", {31'h0, irq}, 32'h0);
        haltReq <= 0;
        // Reset in mid conversion; the result pair must survive it
        wr(OFF_CTRL, 32'h5);
        wr(OFF_CTRL, 32'h15);
        reset_n <= 0;
        repeat (2) @(posedge clk);
        reset_n <= 1;
        check("enable", {31'h0, converterEnable}, 32'h0);
        rd(OFF_CTRL);
        check("ctrl", rdVal, 32'h0);
        rd(OFF_MASK);
        check("mask", rdVal, 32'h0);
        rd(OFF_RESULT);
        check("result", rdVal, {22'h0, SAMPLE});
        close_out();
    end
endmodule : asarc_control_tb
